// [fem_pkg.sv]
// constants and types of the fault event message generator
package fem_pkg;
  localparam logic [7:0] FEM_OFF_CTRL = 8'h38;
  localparam logic [7:0] FEM_OFF_DATA = 8'h3c;
  localparam logic [7:0] FEM_OFF_ADDR = 8'h40;
  localparam logic [7:0] FEM_OFF_UADDR = 8'h44;
  localparam logic [7:0] FEM_OFF_IRQ_STAT = 8'h50;
  localparam logic [7:0] FEM_OFF_IRQ_CLR = 8'h54;
  localparam logic [7:0] FEM_OFF_IRQ_EN = 8'h58;
  localparam int FEM_ADDR_W = 8;
  localparam int FEM_MASK_BIT = 31;
  localparam int FEM_PEND_BIT = 30;
  localparam int FEM_DATA_W = 16;
  localparam int FEM_MA_LSB = 2;
  localparam int FEM_NUM_FRCD = 4;
  localparam int FEM_NUM_STAT = 4;
  localparam int FEM_NUM_IRQ = 2;
  localparam int FEM_IRQ_SENT = 0;
  localparam int FEM_IRQ_COND = 1;
  localparam logic FEM_EXT_MODE = 1'b1;
  localparam logic FEM_MASK_RST = 1'b1;
  localparam logic [15:0] FEM_DATA_RST = 16'h0000;
  localparam logic [29:0] FEM_ADDR_RST = 30'h0000_0000;
  localparam logic [31:0] FEM_UADDR_RST = 32'h0000_0000;
  localparam logic [31:0] FEM_ZERO_WORD = 32'h0000_0000;
  localparam logic [1:0] FEM_HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {
    FEM_ST_IDLE = 2'b01,
    FEM_ST_SEND = 2'b10
  } fem_state_t;
endpackage

// [fem_msg_gen.sv]
// fault event interrupt message generator with ahb-lite registers
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// What this block does
// RQ1 - with the mask clear, each interrupt condition leads to a message built from the data and address registers.
// RQ2 - the mask bit is control bit 31, resets to 1, and while set no message leaves; a message already waiting for msg_ready when it is set is still sent.
// RQ3 - with primary logging active, a newly recorded fault setting any_fault_logged sets the pending flag, bit 30.
// RQ4 - a new queue error status is an interrupt condition and sets the pending flag.
// RQ5 - a new bad device-tlb completion status is an interrupt condition and sets the pending flag.
// RQ6 - a new device-tlb completion time-out status is an interrupt condition and sets the pending flag.
// RQ7 - a status bit that rises while any status bit was already set is no new condition.
// RQ8 - the pending flag stays set while the message is held back by the mask or a busy far side.
// RQ9 - the pending flag clears once the message is sent, after unmasking or when the far side accepts.
// RQ10 - the pending flag clears when all recording valid flags clear and any_fault_logged and the three other status bits read clear.
// RQ11 - software clears the other status bits by writing them back, after which they count as serviced.
// RQ12 - the data register holds a 16-bit read-write value in bits 15:0, upper bits read zero.
// RQ13 - the address register holds a dword-aligned address in bits 31:2, bits 1:0 read zero.
// RQ14 - the upper address register is a full 32-bit read-write word when extended mode is present.
// RQ15 - any_fault_logged is the or of the valid flags of all recording registers.
// RQ16 - the message is one dword write of the data to the upper address joined with the lower address.
//////////////////////////////////////////////////////////////////////////////
module fem_msg_gen (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic primary_logging_active,
  input wire logic [fem_pkg::FEM_NUM_FRCD-1:0] frcd_valid,
  input wire logic queue_error_status,
  input wire logic bad_devtlb_completion,
  input wire logic devtlb_completion_timeout,
  output logic any_fault_logged,
  output logic msg_valid,
  input wire logic msg_ready,
  output logic [63:0] msg_addr,
  output logic [31:0] msg_data,
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  logic mask_r;
  logic mask_nxt;
  logic pending_r;
  logic pending_nxt;
  logic [15:0] data_r;
  logic [15:0] data_nxt;
  logic [29:0] addr_r;
  logic [29:0] addr_nxt;
  logic [31:0] uaddr_r;
  logic [31:0] uaddr_nxt;
  logic [fem_pkg::FEM_NUM_STAT-1:0] stat_prev_r;
  logic [fem_pkg::FEM_NUM_STAT-1:0] stat_prev_nxt;
  logic [fem_pkg::FEM_NUM_STAT-1:0] stat_cur;
  logic [fem_pkg::FEM_NUM_STAT-1:0] stat_rise;
  logic new_cond;
  logic serviced;
  fem_pkg::fem_state_t state_r;
  fem_pkg::fem_state_t state_nxt;
  logic [63:0] maddr_r;
  logic [63:0] maddr_nxt;
  logic [31:0] mdata_r;
  logic [31:0] mdata_nxt;
  logic sent;
  logic launch;
  logic [fem_pkg::FEM_NUM_IRQ-1:0] istat_r;
  logic [fem_pkg::FEM_NUM_IRQ-1:0] istat_nxt;
  logic [fem_pkg::FEM_NUM_IRQ-1:0] ien_r;
  logic [fem_pkg::FEM_NUM_IRQ-1:0] ien_nxt;
  logic [fem_pkg::FEM_NUM_IRQ-1:0] iset;
  logic [fem_pkg::FEM_NUM_IRQ-1:0] iclr;
  logic dph_r;
  logic dph_nxt;
  logic dwr_r;
  logic dwr_nxt;
  logic [7:0] daddr_r;
  logic [7:0] daddr_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic aphase;
  logic wr_ctrl;
  logic wr_data;
  logic wr_addr;
  logic wr_uaddr;
  logic wr_iclr;
  logic wr_ien;

  function automatic logic [31:0] fem_read(input logic [7:0] a,
                                           input logic m,
                                           input logic p,
                                           input logic [15:0] d,
                                           input logic [29:0] ad,
                                           input logic [31:0] ua,
                                           input logic [1:0] is,
                                           input logic [1:0] ie);
    logic [31:0] v;
    v = fem_pkg::FEM_ZERO_WORD;
    case (a)
      fem_pkg::FEM_OFF_CTRL: begin
        v[fem_pkg::FEM_MASK_BIT] = m;
        v[fem_pkg::FEM_PEND_BIT] = p;
      end
      fem_pkg::FEM_OFF_DATA: v[fem_pkg::FEM_DATA_W-1:0] = d; // [RQ12]
      fem_pkg::FEM_OFF_ADDR: v[31:fem_pkg::FEM_MA_LSB] = ad; // [RQ13]
      fem_pkg::FEM_OFF_UADDR: v = fem_pkg::FEM_EXT_MODE ? ua : fem_pkg::FEM_ZERO_WORD; // [RQ14]
      fem_pkg::FEM_OFF_IRQ_STAT: v[fem_pkg::FEM_NUM_IRQ-1:0] = is;
      fem_pkg::FEM_OFF_IRQ_EN: v[fem_pkg::FEM_NUM_IRQ-1:0] = ie;
      default: v = fem_pkg::FEM_ZERO_WORD;
    endcase
    return v;
  endfunction

  // offset match of the data-phase address
  function automatic logic fem_hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states
  assign aphase = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;
  assign wr_ctrl = dph_r & dwr_r & fem_hit(daddr_r, fem_pkg::FEM_OFF_CTRL);
  assign wr_data = dph_r & dwr_r & fem_hit(daddr_r, fem_pkg::FEM_OFF_DATA);
  assign wr_addr = dph_r & dwr_r & fem_hit(daddr_r, fem_pkg::FEM_OFF_ADDR);
  assign wr_uaddr = dph_r & dwr_r & fem_hit(daddr_r, fem_pkg::FEM_OFF_UADDR);
  assign wr_iclr = dph_r & dwr_r & fem_hit(daddr_r, fem_pkg::FEM_OFF_IRQ_CLR);
  assign wr_ien = dph_r & dwr_r & fem_hit(daddr_r, fem_pkg::FEM_OFF_IRQ_EN);

  always_comb begin
    dph_nxt = aphase;
    dwr_nxt = aphase & hwrite;
    daddr_nxt = daddr_r;
    if (aphase) begin
      daddr_nxt = haddr[fem_pkg::FEM_ADDR_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dph_r <= 1'b0;
      dwr_r <= 1'b0;
      daddr_r <= 8'h00;
    end else begin
      dph_r <= dph_nxt;
      dwr_r <= dwr_nxt;
      daddr_r <= daddr_nxt;
    end
  end

  always_comb begin
    rdata_nxt = rdata_r;
    if (aphase && !hwrite) begin
      rdata_nxt = fem_read(haddr[fem_pkg::FEM_ADDR_W-1:0], mask_r, pending_r, data_r, addr_r, uaddr_r,
                           istat_r, ien_r);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= fem_pkg::FEM_ZERO_WORD;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers
  // mask bit
  always_comb begin
    mask_nxt = mask_r;
    if (wr_ctrl) begin
      mask_nxt = hwdata[fem_pkg::FEM_MASK_BIT];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mask_r <= fem_pkg::FEM_MASK_RST; // [RQ2]
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // message data
  always_comb begin
    data_nxt = data_r;
    if (wr_data) begin
      data_nxt = hwdata[fem_pkg::FEM_DATA_W-1:0]; // [RQ12]
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      data_r <= fem_pkg::FEM_DATA_RST;
    end else begin
      data_r <= data_nxt;
    end
  end

  // message address
  always_comb begin
    addr_nxt = addr_r;
    if (wr_addr) begin
      addr_nxt = hwdata[31:fem_pkg::FEM_MA_LSB]; // [RQ13]
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_r <= fem_pkg::FEM_ADDR_RST;
    end else begin
      addr_r <= addr_nxt;
    end
  end

  // upper message address
  always_comb begin
    uaddr_nxt = uaddr_r;
    if (wr_uaddr && fem_pkg::FEM_EXT_MODE) begin
      uaddr_nxt = hwdata; // [RQ14]
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      uaddr_r <= fem_pkg::FEM_UADDR_RST;
    end else begin
      uaddr_r <= uaddr_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // condition detection and pending flag
  assign any_fault_logged = |frcd_valid; // [RQ15]
  assign stat_cur = {devtlb_completion_timeout, bad_devtlb_completion, queue_error_status, any_fault_logged};

  always_comb begin
    stat_prev_nxt = stat_cur;
    stat_rise = stat_cur & ~stat_prev_r;
    stat_rise[0] = stat_rise[0] & primary_logging_active; // [RQ3]
    new_cond = (|stat_rise) & ~(|stat_prev_r); // [RQ4] [RQ5] [RQ6] [RQ7]
    serviced = ~(|stat_cur); // [RQ10] [RQ11]
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stat_prev_r <= 4'h0;
    end else begin
      stat_prev_r <= stat_prev_nxt;
    end
  end

  always_comb begin
    pending_nxt = pending_r; // [RQ8]
    if (new_cond) begin
      pending_nxt = 1'b1; // [RQ3]
    end else if (sent) begin
      pending_nxt = 1'b0; // [RQ9]
    end else if (serviced) begin
      pending_nxt = 1'b0; // [RQ10] [RQ11]
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pending_r <= 1'b0;
    end else begin
      pending_r <= pending_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // message write sequencer
  assign msg_valid = (state_r == fem_pkg::FEM_ST_SEND);
  assign msg_addr = maddr_r;
  assign msg_data = mdata_r;
  assign sent = msg_valid & msg_ready;
  assign launch = (state_r == fem_pkg::FEM_ST_IDLE) & pending_r & ~mask_r; // [RQ1] [RQ2]

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      fem_pkg::FEM_ST_IDLE: begin
        if (launch) begin // [RQ1] [RQ2]
          state_nxt = fem_pkg::FEM_ST_SEND;
        end
      end
      fem_pkg::FEM_ST_SEND: begin
        if (msg_ready) begin // [RQ8] [RQ9]
          state_nxt = fem_pkg::FEM_ST_IDLE;
        end
      end
      default: begin
        state_nxt = fem_pkg::FEM_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= fem_pkg::FEM_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_comb begin
    maddr_nxt = maddr_r;
    mdata_nxt = mdata_r;
    if (launch) begin
      maddr_nxt = {uaddr_r, addr_r, 2'b00}; // [RQ16]
      mdata_nxt = {16'h0000, data_r}; // [RQ16]
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      maddr_r <= 64'h0000_0000_0000_0000;
      mdata_r <= fem_pkg::FEM_ZERO_WORD;
    end else begin
      maddr_r <= maddr_nxt;
      mdata_r <= mdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // local interrupt status, clear and enable
  always_comb begin
    iset = '0;
    iset[fem_pkg::FEM_IRQ_SENT] = sent;
    iset[fem_pkg::FEM_IRQ_COND] = new_cond;
    iclr = '0;
    if (wr_iclr) begin
      iclr = hwdata[fem_pkg::FEM_NUM_IRQ-1:0];
    end
    istat_nxt = (istat_r & ~iclr) | iset;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      istat_r <= 2'h0;
    end else begin
      istat_r <= istat_nxt;
    end
  end

  always_comb begin
    ien_nxt = ien_r;
    if (wr_ien) begin
      ien_nxt = hwdata[fem_pkg::FEM_NUM_IRQ-1:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ien_r <= 2'h0;
    end else begin
      ien_r <= ien_nxt;
    end
  end

  assign irq = |(istat_r & ien_r);

endmodule // fem_msg_gen

// [fem_msg_gen_assertions.sv]
// checker for the fault event message generator
`timescale 1ns/1ps
module fem_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [fem_pkg::FEM_NUM_FRCD-1:0] frcd_valid,
  input wire logic queue_error_status,
  input wire logic bad_devtlb_completion,
  input wire logic devtlb_completion_timeout,
  input wire logic any_fault_logged,
  input wire logic msg_valid,
  input wire logic msg_ready,
  input wire logic [63:0] msg_addr,
  input wire logic [31:0] msg_data,
  input wire logic irq
);
  logic st;
  assign st = queue_error_status | bad_devtlb_completion | devtlb_completion_timeout | any_fault_logged;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_afl_or:
    assert property (any_fault_logged == |frcd_valid) else $error("fault flag not or of valids");
  a_msg_hold:
    assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg_addr) && $stable(msg_data))
      else $error("message dropped or changed while held");
  a_msg_gap:
    assert property (msg_valid && msg_ready |=> !msg_valid) else $error("no gap after message");
  a_valid_drop:
    assert property ($fell(msg_valid) |-> $past(msg_ready)) else $error("message withdrawn");
  a_data_upper:
    assert property (msg_valid |-> msg_data[31:16] == 16'h0000) else $error("message data upper set");
  a_addr_align:
    assert property (msg_valid |-> msg_addr[1:0] == 2'h0) else $error("message address unaligned");
  a_reset_quiet:
    assert property ($fell(rst) |-> !msg_valid && !irq) else $error("output active after reset");
  a_valid_cause:
    assert property ($rose(msg_valid) |-> $past(st, 2)) else $error("message without condition");
endmodule // fem_chk

// [fem_sink.sv]
// message receiver model with random stalls
`timescale 1ns/1ps
module fem_sink (
  input wire logic ref_clk,
  input wire logic stall,
  input wire logic msg_valid,
  output logic msg_ready,
  input wire logic [63:0] msg_addr,
  input wire logic [31:0] msg_data,
  output int n_got,
  output logic [95:0] got
);
  initial msg_ready = 1'b0;
  initial n_got = 0;
  always @(posedge ref_clk) begin
    if (msg_valid && msg_ready) begin
      got <= {msg_addr, msg_data};
      n_got <= n_got + 1;
    end
    msg_ready <= !stall;
  end
endmodule // fem_sink

// [testbench.sv]
// self-checking bench of the fault event message generator
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 0, rst = 1, hsel = 0, hwrite = 0, hready, hreadyout, hresp, any_fault_logged, stall = 0;
  logic primary_logging_active = 0, queue_error_status = 0, bad_devtlb_completion = 0;
  logic devtlb_completion_timeout = 0, msg_valid, msg_ready, irq;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, msg_data, q, d, a, u;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [fem_pkg::FEM_NUM_FRCD-1:0] frcd_valid = 0;
  logic [63:0] msg_addr;
  logic [95:0] got;
  integer seed = 32'h13e9_4ff8;
  int err_count = 0, checked = 0, n_got, n_exp = 0, cyc = 0;
  assign hready = hreadyout;
  always #4 ref_clk = ~ref_clk;
  fem_msg_gen dut_u (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .primary_logging_active, .frcd_valid, .queue_error_status,
    .bad_devtlb_completion, .devtlb_completion_timeout, .any_fault_logged, .msg_valid, .msg_ready,
    .msg_addr, .msg_data, .irq);
  fem_sink sink_u (.ref_clk, .stall, .msg_valid, .msg_ready, .msg_addr, .msg_data, .n_got, .got);
  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, ad};
    htrans <= fem_pkg::FEM_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hready !== 1'b1);
    q = hrdata;
    chk("hresp", 32'h0000_0000, {31'h0, hresp});
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 32'h0000_0000);
    chk("register", e, q);
  endtask
  task automatic stat(input logic [3:0] s);
    frcd_valid <= s[0] ? 4'($random(seed)) | 4'h1 : 4'h0;
    queue_error_status <= s[1];
    bad_devtlb_completion <= s[2];
    devtlb_completion_timeout <= s[3];
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic msg;
    n_exp++;
    for (int i = 0; i < 60 && n_got != n_exp; i++) @(posedge ref_clk);
    chk("msg count", n_exp, n_got);
    chk("msg data", d & 32'h0000_ffff, got[31:0]);
    chk("msg addr lo", a & 32'hffff_fffc, got[63:32]);
    chk("msg addr hi", u, got[95:64]);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    stall <= 1'($random(seed));
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      report_and_stop;
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(fem_pkg::FEM_OFF_CTRL, 32'h8000_0000);
    rd(fem_pkg::FEM_OFF_DATA, 32'h0000_0000);
    rd(fem_pkg::FEM_OFF_ADDR, 32'h0000_0000);
    rd(fem_pkg::FEM_OFF_UADDR, 32'h0000_0000);
    rd(8'h60, 32'h0000_0000);
    d = $random(seed);
    a = $random(seed);
    u = $random(seed);
    bus(1'b1, fem_pkg::FEM_OFF_DATA, d);
    bus(1'b1, fem_pkg::FEM_OFF_ADDR, a);
    bus(1'b1, fem_pkg::FEM_OFF_UADDR, u);
    rd(fem_pkg::FEM_OFF_DATA, d & 32'h0000_ffff);
    rd(fem_pkg::FEM_OFF_ADDR, a & 32'hffff_fffc);
    rd(fem_pkg::FEM_OFF_UADDR, u);
    bus(1'b1, fem_pkg::FEM_OFF_IRQ_EN, 32'h0000_0003);
    stat(4'h2);
    rd(fem_pkg::FEM_OFF_CTRL, 32'hc000_0000);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    chk("msg count", 32'h0000_0000, n_got);
    bus(1'b1, fem_pkg::FEM_OFF_CTRL, 32'h0000_0000);
    msg();
    rd(fem_pkg::FEM_OFF_CTRL, 32'h0000_0000);
    rd(fem_pkg::FEM_OFF_IRQ_STAT, 32'h0000_0003);
    bus(1'b1, fem_pkg::FEM_OFF_IRQ_CLR, 32'h0000_0003);
    rd(fem_pkg::FEM_OFF_IRQ_STAT, 32'h0000_0000);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    stat(4'h0);
    stat(4'h1);
    rd(fem_pkg::FEM_OFF_IRQ_STAT, 32'h0000_0000);
    stat(4'h0);
    primary_logging_active <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      stat(4'(1 << i));
      msg();
      stat(4'hf);
      rd(fem_pkg::FEM_OFF_CTRL, 32'h0000_0000);
      stat(4'h0);
    end
    bus(1'b1, fem_pkg::FEM_OFF_CTRL, 32'h8000_0000);
    stat(4'h1);
    repeat (20) @(posedge ref_clk);
    rd(fem_pkg::FEM_OFF_CTRL, 32'hc000_0000);
    stat(4'h0);
    rd(fem_pkg::FEM_OFF_CTRL, 32'h8000_0000);
    stat(4'h2);
    rd(fem_pkg::FEM_OFF_CTRL, 32'hc000_0000);
    stat(4'h0);
    rd(fem_pkg::FEM_OFF_CTRL, 32'h8000_0000);
    bus(1'b1, fem_pkg::FEM_OFF_CTRL, 32'h0000_0000);
    repeat (10) @(posedge ref_clk);
    chk("msg count", n_exp, n_got);
    report_and_stop;
  end
endmodule // testbench
bind fem_msg_gen fem_chk chk_u (.ref_clk, .rst, .frcd_valid, .queue_error_status, .bad_devtlb_completion,
  .devtlb_completion_timeout, .any_fault_logged, .msg_valid, .msg_ready, .msg_addr, .msg_data, .irq);
